// ---- design/irq_pkg.sv ----
// Shared constants of the interrupt controller: register map, bit layout, vectors, sizes.
package irq_pkg;
	localparam int         PC_WIDTH        = 12;
	localparam int         STACK_DEPTH     = 8;
	localparam int         ENDPOINT_COUNT  = 4;
	localparam int         SOURCE_COUNT    = 3;
	localparam logic [7:0] CONTROL_ADDR    = 8'h0B;
	localparam logic [7:0] USB_CTL_ADDR    = 8'h1A;
	localparam logic [7:0] EP_STATUS_ADDR  = 8'h1B;
	localparam int         GIE_BIT         = 0;
	localparam int         ENABLE_LSB      = 1;
	localparam int         PENDING_LSB     = 4;
	localparam int         SUSPEND_BIT     = 0;
	localparam int         RESUME_BIT      = 3;
	localparam int         SRC_USB         = 0;
	localparam int         SRC_TIMER_A     = 1;
	localparam int         SRC_TIMER_B     = 2;
	localparam logic [11:0] USB_VECTOR     = 12'h004;
	localparam logic [11:0] TIMER_A_VECTOR = 12'h008;
	localparam logic [11:0] TIMER_B_VECTOR = 12'h00C;
	localparam logic [7:0] CONTROL_RESET   = 8'h00;
	localparam logic [7:0] USB_CTL_RESET   = 8'h00;
	localparam logic [7:0] EP_STATUS_RESET = 8'h00;
	localparam logic [7:0] USB_CTL_MASK    = 8'h09;
	localparam logic [7:0] READ_IDLE       = 8'h00;
endpackage : irq_pkg

// ---- design/irq_return_stack.sv ----
// Eight-level program counter return stack with a full flag and overwrite of the oldest entry.
module irq_return_stack #(
	parameter int DEPTH = irq_pkg::STACK_DEPTH,
	parameter int WIDTH = irq_pkg::PC_WIDTH
) (
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	// Push and pop.
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] push_data,
	output logic      [WIDTH-1:0] top_data,
	// State.
	output logic      [3:0]       level,
	output logic                  full
);
	logic [WIDTH-1:0]       entry_mem [DEPTH];
	logic [$clog2(DEPTH)-1:0] head_reg;
	logic [3:0]             level_reg;
	logic [$clog2(DEPTH)-1:0] top_idx;

	assign top_idx  = head_reg - 1'b1;
	assign top_data = entry_mem[top_idx];
	assign level    = level_reg;
	assign full     = (level_reg == 4'(DEPTH));

	// A push when full overwrites the oldest word; only the last eight survive.
	always_ff @(posedge ref_clk)
	begin
		if (push && !pop)
		begin
			entry_mem[head_reg] <= push_data;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			head_reg  <= '0;
			level_reg <= 4'h0;
		end
		else if (pop)
		begin
			if (level_reg != 4'h0)
			begin
				head_reg  <= top_idx;
				level_reg <= level_reg - 4'h1;
			end
		end
		else if (push)
		begin
			head_reg <= head_reg + 1'b1;
			if (level_reg != 4'(DEPTH))
			begin
				level_reg <= level_reg + 4'h1;
			end
		end
	end

	a_level_bound : assert property (@(posedge ref_clk) disable iff (!resetn)
		level_reg <= 4'(DEPTH)) else $error("Stack level above depth.");
endmodule : irq_return_stack

// ---- design/mcu_interrupt_controller.sv ----
// Interrupt controller: control register, USB status bits, priority vectoring, stack, wake-up.

module mcu_interrupt_controller #(
	parameter int PC_WIDTH    = irq_pkg::PC_WIDTH,
	parameter int EP_COUNT    = irq_pkg::ENDPOINT_COUNT,
	parameter int STACK_DEPTH = irq_pkg::STACK_DEPTH
) (
	// Clock and reset.
	input  wire logic                ref_clk,
	input  wire logic                resetn,
	// Data memory register port.
	input  wire logic [7:0]          reg_addr,
	input  wire logic                reg_wr_en,
	input  wire logic [7:0]          reg_wr_data,
	input  wire logic                reg_rd_en,
	output logic      [7:0]          reg_rd_data,
	// Core sequencer.
	input  wire logic                cycle_phase_two_pulse,
	input  wire logic [PC_WIDTH-1:0] pc_now,
	input  wire logic                call_instr,
	input  wire logic                plain_return_instr,
	input  wire logic                return_from_irq_instr,
	input  wire logic                halt_enter,
	output logic                     irq_ack,
	output logic      [PC_WIDTH-1:0] irq_vector,
	output logic      [PC_WIDTH-1:0] return_pc,
	output logic                     stack_full,
	output logic                     wake_req,
	// Event sources.
	input  wire logic [EP_COUNT-1:0] usb_fifo_access,
	input  wire logic                usb_suspend,
	input  wire logic                usb_resume,
	input  wire logic                usb_bus_reset,
	input  wire logic                timer_a_overflow,
	input  wire logic                timer_b_overflow
);
	localparam int N = irq_pkg::SOURCE_COUNT;

	logic                global_irq_enable_reg;
	logic [N-1:0]        irq_enable_reg;
	logic [N-1:0]        irq_pending_reg;
	logic [N-1:0]        irq_pending_next;
	logic [7:0]          usb_ctl_status_reg;
	logic [EP_COUNT-1:0] endpoint_access_status_reg;
	logic [N-1:0]        src_event;
	logic [N-1:0]        request;
	logic [N-1:0]        ack_sel;
	logic                ack_fire;
	logic                control_wr;
	logic                usb_ctl_wr;
	logic                ep_status_wr;
	logic                halt_active_reg;
	logic [N-1:0]        halt_mask_reg;
	logic                wake_reg;
	logic                irq_ack_reg;
	logic [PC_WIDTH-1:0] irq_vector_reg;
	logic [7:0]          reg_rd_data_reg;
	logic [3:0]          stack_level;
	logic [7:0]          control_value;

	// Picks the highest-priority request as a one-hot word.
	function automatic logic [N-1:0] first_request(input logic [N-1:0] req);
		logic [N-1:0] sel;
		sel = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				sel = '0;
				sel[i] = 1'b1;
			end
		end
		return sel;
	endfunction : first_request

	// Maps a one-hot source selection to its entry address.
	function automatic logic [PC_WIDTH-1:0] vector_of(input logic [N-1:0] sel);
		logic [PC_WIDTH-1:0] v;
		v = PC_WIDTH'(irq_pkg::TIMER_B_VECTOR);
		if (sel[irq_pkg::SRC_USB])
		begin
			v = PC_WIDTH'(irq_pkg::USB_VECTOR);
		end
		else if (sel[irq_pkg::SRC_TIMER_A])
		begin
			v = PC_WIDTH'(irq_pkg::TIMER_A_VECTOR);
		end
		return v;
	endfunction : vector_of

	assign control_wr   = reg_wr_en && (reg_addr == irq_pkg::CONTROL_ADDR);
	assign usb_ctl_wr   = reg_wr_en && (reg_addr == irq_pkg::USB_CTL_ADDR);
	assign ep_status_wr = reg_wr_en && (reg_addr == irq_pkg::EP_STATUS_ADDR);

	// Any USB event raises the single USB request.
	assign src_event[irq_pkg::SRC_USB]     = (|usb_fifo_access) | usb_suspend
		| usb_resume | usb_bus_reset;
	assign src_event[irq_pkg::SRC_TIMER_A] = timer_a_overflow;
	assign src_event[irq_pkg::SRC_TIMER_B] = timer_b_overflow;

	// A request needs its own and the global enable, and waits while the stack is full.
	assign request  = irq_pending_reg & irq_enable_reg & {N{global_irq_enable_reg}};
	assign ack_sel  = first_request(request);
	assign ack_fire = cycle_phase_two_pulse && (|request) && !stack_full;

	assign control_value = {1'b0, irq_pending_reg, irq_enable_reg, global_irq_enable_reg};

	// Pending flags: software write, then acknowledge clear, then new events win.
	always_comb
	begin
		irq_pending_next = irq_pending_reg;
		if (control_wr)
		begin
			irq_pending_next = reg_wr_data[irq_pkg::PENDING_LSB +: N];
		end
		if (ack_fire)
		begin
			irq_pending_next = irq_pending_next & ~ack_sel;
		end
		irq_pending_next = irq_pending_next | src_event;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			irq_pending_reg <= irq_pkg::CONTROL_RESET[irq_pkg::PENDING_LSB +: N];
		end
		else
		begin
			irq_pending_reg <= irq_pending_next;
		end
	end

	// Enables and global enable; acknowledge beats return and write on the global bit.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			irq_enable_reg        <= irq_pkg::CONTROL_RESET[irq_pkg::ENABLE_LSB +: N];
			global_irq_enable_reg <= irq_pkg::CONTROL_RESET[irq_pkg::GIE_BIT];
		end
		else
		begin
			if (control_wr)
			begin
				irq_enable_reg <= reg_wr_data[irq_pkg::ENABLE_LSB +: N];
			end
			if (ack_fire)
			begin
				global_irq_enable_reg <= 1'b0;
			end
			else if (control_wr)
			begin
				global_irq_enable_reg <= reg_wr_data[irq_pkg::GIE_BIT];
			end
			else if (return_from_irq_instr)
			begin
				global_irq_enable_reg <= 1'b1;
			end
		end
	end

	// USB status bits: hardware set wins over a firmware clear in the same cycle.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			usb_ctl_status_reg         <= irq_pkg::USB_CTL_RESET;
			endpoint_access_status_reg <= irq_pkg::EP_STATUS_RESET[EP_COUNT-1:0];
		end
		else
		begin
			usb_ctl_status_reg <= (usb_ctl_wr ? (reg_wr_data & irq_pkg::USB_CTL_MASK)
				: usb_ctl_status_reg)
				| (8'(usb_suspend) << irq_pkg::SUSPEND_BIT)
				| (8'(usb_resume) << irq_pkg::RESUME_BIT);
			endpoint_access_status_reg <= (ep_status_wr ? reg_wr_data[EP_COUNT-1:0]
				: endpoint_access_status_reg) | usb_fifo_access;
		end
	end

	// Acknowledge pulse and vector, one cycle after the phase-two pulse.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			irq_ack_reg    <= 1'b0;
			irq_vector_reg <= '0;
		end
		else
		begin
			irq_ack_reg <= ack_fire;
			if (ack_fire)
			begin
				irq_vector_reg <= vector_of(ack_sel);
			end
		end
	end

	// Halt: sources already pending at entry are masked from waking.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			halt_active_reg <= 1'b0;
			halt_mask_reg   <= '0;
			wake_reg        <= 1'b0;
		end
		else
		begin
			wake_reg <= 1'b0;
			if (halt_enter)
			begin
				halt_active_reg <= 1'b1;
				halt_mask_reg   <= irq_pending_reg;
			end
			else if (halt_active_reg && |(src_event & ~halt_mask_reg))
			begin
				halt_active_reg <= 1'b0;
				wake_reg        <= 1'b1;
			end
		end
	end

	// Registered read; unmapped addresses read zero.
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			reg_rd_data_reg <= irq_pkg::READ_IDLE;
		end
		else if (reg_rd_en)
		begin
			case (reg_addr)
				irq_pkg::CONTROL_ADDR:   reg_rd_data_reg <= control_value;
				irq_pkg::USB_CTL_ADDR:   reg_rd_data_reg <= usb_ctl_status_reg;
				irq_pkg::EP_STATUS_ADDR: reg_rd_data_reg <= 8'(endpoint_access_status_reg);
				default:                 reg_rd_data_reg <= irq_pkg::READ_IDLE;
			endcase
		end
	end

	// Only the program counter is saved on acknowledge or call.
	irq_return_stack #(
		.DEPTH (STACK_DEPTH),
		.WIDTH (PC_WIDTH)
	) u_stack (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.push      (ack_fire | call_instr),
		.pop       (plain_return_instr | return_from_irq_instr),
		.push_data (pc_now),
		.top_data  (return_pc),
		.level     (stack_level),
		.full      (stack_full)
	);

	assign irq_ack     = irq_ack_reg;
	assign irq_vector  = irq_vector_reg;
	assign wake_req    = wake_reg;
	assign reg_rd_data = reg_rd_data_reg;

	a_ack_clears_gie : assert property (@(posedge ref_clk) disable iff (!resetn)
		ack_fire |=> !global_irq_enable_reg && irq_ack) else $error("Global enable kept.");
	a_nest_service : assert property (@(posedge ref_clk) disable iff (!resetn)
		cycle_phase_two_pulse && global_irq_enable_reg && |(irq_pending_reg & irq_enable_reg)
		&& !stack_full |=> irq_ack) else $error("Enabled request not served.");
	a_full_blocks : assert property (@(posedge ref_clk) disable iff (!resetn)
		stack_full |=> !irq_ack) else $error("Acknowledge with full stack.");
	a_ack_pushes : assert property (@(posedge ref_clk) disable iff (!resetn)
		ack_fire && !plain_return_instr && !return_from_irq_instr
		|=> stack_level == $past(stack_level) + 4'h1) else $error("Acknowledge did not push.");
	a_usb_vector : assert property (@(posedge ref_clk) disable iff (!resetn)
		ack_fire && request[0] |=> irq_vector == 12'h004) else $error("Bad USB vector.");
	a_timer_a_vector : assert property (@(posedge ref_clk) disable iff (!resetn)
		ack_fire && request == 3'b010 |=> irq_vector == 12'h008
		&& (!irq_pending_reg[1] || $past(src_event[1]))) else $error("Bad timer A service.");
	a_timer_b_vector : assert property (@(posedge ref_clk) disable iff (!resetn)
		ack_fire && request == 3'b100 |=> irq_vector == 12'h00C) else $error("Bad timer B vector.");
	a_priority_order : assert property (@(posedge ref_clk) disable iff (!resetn)
		ack_fire && request[1] && !request[0] |=> irq_vector == 12'h008)
		else $error("Priority broken.");
	a_return_from_irq_instr_enables : assert property (@(posedge ref_clk) disable iff (!resetn)
		return_from_irq_instr && !ack_fire && !control_wr |=> global_irq_enable_reg)
		else $error("Return did not enable.");
	a_ret_keeps : assert property (@(posedge ref_clk) disable iff (!resetn)
		plain_return_instr && !return_from_irq_instr && !ack_fire && !control_wr
		|=> $stable(global_irq_enable_reg)) else $error("Plain return changed enable.");
	a_flag_sticky : assert property (@(posedge ref_clk) disable iff (!resetn)
		!control_wr && !ack_fire |=> (irq_pending_reg & $past(irq_pending_reg))
		== $past(irq_pending_reg)) else $error("Pending flag lost.");
	a_phase_only : assert property (@(posedge ref_clk) disable iff (!resetn)
		!cycle_phase_two_pulse |=> !irq_ack) else $error("Acknowledge off phase.");
	a_suspend_sets : assert property (@(posedge ref_clk) disable iff (!resetn)
		usb_suspend |=> usb_ctl_status_reg[0] && irq_pending_reg[0]) else $error("Suspend lost.");
	a_wake_event : assert property (@(posedge ref_clk) disable iff (!resetn)
		halt_active_reg && !halt_enter && |(src_event & ~halt_mask_reg) |=> wake_req)
		else $error("No wake.");
endmodule : mcu_interrupt_controller

// ---- tb/core_model.sv ----
// Core sequencer model: a phase-two pulse every fourth cycle and a running program counter.
module core_model (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Sequencer outputs.
	output logic             phase_pulse,
	output logic      [11:0] pc_now
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] step_reg;

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			step_reg    <= 2'h0;
			phase_pulse <= 1'b0;
			pc_now      <= 12'h100;
		end
		else
		begin
			step_reg    <= step_reg + 2'h1;
			phase_pulse <= (step_reg == 2'h3);
			if (phase_pulse)
				pc_now <= pc_now + 12'h001;
		end
	end
endmodule : core_model

// ---- tb/test_mcu_interrupt_controller.sv ----
// Self-checking testbench of the interrupt controller.
module test_mcu_interrupt_controller;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [12:0] EV_SUSP = 13'h0100;
	localparam logic [12:0] EV_RESM = 13'h0080;
	localparam logic [12:0] EV_BRST = 13'h0040;
	localparam logic [12:0] EV_TA   = 13'h0020;
	localparam logic [12:0] EV_TB   = 13'h0010;
	localparam logic [12:0] EV_CALL = 13'h0008;
	localparam logic [12:0] EV_POP_KEEP   = 13'h0004;
	localparam logic [12:0] EV_POP_ENABLE = 13'h0002;
	localparam logic [12:0] EV_HALT = 13'h0001;
	localparam logic [12:0] SRC_EV [3] = '{EV_SUSP, EV_TA, EV_TB};

	logic        ref_clk     = 1'b0;
	logic        resetn      = 1'b0;
	logic [7:0]  reg_addr    = 8'h00;
	logic        reg_wr_en   = 1'b0;
	logic [7:0]  reg_wr_data = 8'h00;
	logic        reg_rd_en   = 1'b0;
	logic [12:0] ev          = 13'h0000;
	logic [7:0]  reg_rd_data;
	logic        phase_pulse;
	logic [11:0] pc_now;
	logic        irq_ack;
	logic [11:0] irq_vector;
	logic [11:0] return_pc;
	logic        stack_full;
	logic        wake_req;
	logic [11:0] ack_vec;
	logic [11:0] ack_pc;
	logic [11:0] pc_d1;
	logic        ack_ph;
	logic        ph_d1       = 1'b0;
	int          fail_count  = 0;
	int          checks_done = 0;
	int          cycles      = 0;
	int          ack_cnt     = 0;
	int          wake_cnt    = 0;

	core_model core_u (.ref_clk(ref_clk), .resetn(resetn), .phase_pulse(phase_pulse),
		.pc_now(pc_now));

	mcu_interrupt_controller dut_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
		.reg_rd_data(reg_rd_data), .cycle_phase_two_pulse(phase_pulse), .pc_now(pc_now),
		.call_instr(ev[3]), .plain_return_instr(ev[2]), .return_from_irq_instr(ev[1]),
		.halt_enter(ev[0]), .irq_ack(irq_ack), .irq_vector(irq_vector),
		.return_pc(return_pc), .stack_full(stack_full), .wake_req(wake_req),
		.usb_fifo_access(ev[12:9]), .usb_suspend(ev[8]), .usb_resume(ev[7]),
		.usb_bus_reset(ev[6]), .timer_a_overflow(ev[5]), .timer_b_overflow(ev[4]));

	initial
	begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic report_and_stop();
		$display("Checks made: %0d, mismatches: %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	always @(posedge ref_clk)
	begin
		cycles = cycles + 1;
		if (irq_ack === 1'b1)
		begin
			ack_cnt = ack_cnt + 1;
			ack_vec = irq_vector;
			ack_pc = pc_d1;
			ack_ph = ph_d1;
		end
		if (wake_req === 1'b1)
			wake_cnt = wake_cnt + 1;
		ph_d1 = phase_pulse;
		pc_d1 = pc_now;
		if (cycles == 4000)
		begin
			fail_count = fail_count + 1;
			report_and_stop();
		end
	end

	task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic do_reset();
		@(negedge ref_clk);
		resetn = 1'b0;
		repeat (2) @(negedge ref_clk);
		resetn = 1'b1;
	endtask : do_reset

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge ref_clk);
		reg_wr_en = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge ref_clk);
		reg_rd_en = 1'b0;
		check(name, {4'h0, reg_rd_data}, {4'h0, exp});
	endtask : rd

	task automatic pulse(input logic [12:0] v);
		@(negedge ref_clk);
		ev = v;
		@(negedge ref_clk);
		ev = 13'h0000;
	endtask : pulse

	task automatic wait_ack(input logic [11:0] vec);
		int start;
		start = ack_cnt;
		repeat (40) if (ack_cnt == start) @(negedge ref_clk);
		check("ack_seen", 12'(ack_cnt - start), 12'h001);
		check("ack_vector", ack_vec, vec);
		check("ack_pushed_pc", return_pc, ack_pc);
		check("ack_on_phase", {11'h000, ack_ph}, 12'h001);
	endtask : wait_ack

	task automatic s_regs();
		rd(8'h0B, 8'h00, "control_reset");
		rd(8'h1A, 8'h00, "usb_ctl_reset");
		wr(8'h0B, 8'h8F);
		rd(8'h0B, 8'h0F, "control_enables");
		wr(8'h1C, 8'h55);
		rd(8'h1C, 8'h00, "unmapped_read");
	endtask : s_regs

	task automatic s_timer();
		do_reset();
		wr(8'h0B, 8'h05);
		pulse(EV_TA);
		wait_ack(12'h008);
		rd(8'h0B, 8'h04, "after_timer_a_ack");
		pulse(EV_TB);
		rd(8'h0B, 8'h44, "timer_b_held");
		wr(8'h0B, 8'h4D);
		wait_ack(12'h00C);
		rd(8'h0B, 8'h0C, "after_nested_ack");
	endtask : s_timer

	task automatic s_priority();
		do_reset();
		wr(8'h0B, 8'h0E);
		pulse(EV_SUSP | EV_TA | EV_TB);
		rd(8'h0B, 8'h7E, "masked_pending");
		rd(8'h1A, 8'h01, "suspend_bit");
		wr(8'h0B, 8'h7F);
		wait_ack(12'h004);
		rd(8'h0B, 8'h6E, "after_usb_ack");
		pulse(EV_POP_ENABLE);
		wait_ack(12'h008);
		pulse(EV_POP_ENABLE);
		wait_ack(12'h00C);
		pulse(EV_POP_KEEP);
		rd(8'h0B, 8'h0E, "plain_return");
	endtask : s_priority

	task automatic s_usb();
		do_reset();
		pulse(13'h0800 | EV_RESM);
		rd(8'h1B, 8'h04, "endpoint_bit");
		rd(8'h1A, 8'h08, "resume_bit");
		rd(8'h0B, 8'h10, "usb_pending");
		wr(8'h0B, 8'h00);
		pulse(EV_BRST);
		rd(8'h0B, 8'h10, "bus_reset_req");
		wr(8'h1B, 8'h00);
		rd(8'h1B, 8'h00, "endpoint_clear");
	endtask : s_usb

	task automatic s_stack();
		do_reset();
		repeat (7) pulse(EV_CALL);
		check("full_after_7", {11'h000, stack_full}, 12'h000);
		pulse(EV_CALL);
		check("full_after_8", {11'h000, stack_full}, 12'h001);
		wr(8'h0B, 8'h05);
		pulse(EV_TA);
		repeat (12) @(negedge ref_clk);
		rd(8'h0B, 8'h25, "held_while_full");
		pulse(EV_POP_KEEP);
		wait_ack(12'h008);
	endtask : s_stack

	task automatic s_halt();
		int n;
		do_reset();
		for (int i = 0; i < 3; i++)
		begin
			pulse(EV_HALT);
			n = wake_cnt;
			pulse(SRC_EV[i]);
			repeat (3) @(negedge ref_clk);
			check("wake_by_source", 12'(wake_cnt - n), 12'h001);
		end
		pulse(EV_HALT);
		n = wake_cnt;
		pulse(EV_TA);
		repeat (3) @(negedge ref_clk);
		check("wake_when_pending", 12'(wake_cnt - n), 12'h000);
	endtask : s_halt

	initial
	begin
		repeat (2) @(negedge ref_clk);
		resetn = 1'b1;
		s_regs();
		s_timer();
		s_priority();
		s_usb();
		s_stack();
		s_halt();
		report_and_stop();
	end
endmodule : test_mcu_interrupt_controller
